// ===== sps_defines.svh
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SPS_OFS_DATA 12'h000
`define SPS_OFS_CTRL 12'h004
`define SPS_OFS_STAT 12'h008

// ****************************************
// reset values and write masks
// ****************************************
`define SPS_CTRL_RST 8'h00
`define SPS_STAT_RST 8'h00
`define SPS_BUF_RST 8'h00
`define SPS_CTRL_WMASK 8'hDF

// ****************************************
// status bit positions
// ****************************************
`define SPS_BIT_TCF 7
`define SPS_BIT_COLL 6
`define SPS_BIT_FAULT 4

// ****************************************
// timing counts
// ****************************************
`define SPS_LAST_BIT 3'h7
`define SPS_DIV0 4
`define SPS_DIV1 8
`define SPS_DIV2 16
`define SPS_DIV3 32
`define SPS_MIN_DIV 4

`endif

// ===== sps_pkg.sv
package sps_pkg;

    // ****************************************
    // register field layouts
    // ****************************************
    typedef struct packed {
        logic port_irq_enable;
        logic port_enable;
        logic rsvd;
        logic master_select;
        logic clock_polarity;
        logic clock_phase;
        logic rate_sel_hi;
        logic rate_sel_lo;
    } sps_ctrl_t;

    typedef struct packed {
        logic transfer_complete_flag;
        logic write_collision_flag;
        logic rsvd5;
        logic mode_fault_flag;
        logic [3:0] rsvd;
    } sps_stat_t;

    typedef enum logic [0:0] {
        SPS_IDLE = 1'b0,
        SPS_SHIFT = 1'b1
    } sps_state_t;

endpackage

// ===== sps_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module sps_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("sps_pin_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // sps_pin_sync

`default_nettype wire

// ===== sps_rate_div.sv
`timescale 1ns/1ns
`default_nettype none
`include "sps_defines.svh"

module sps_rate_div #(
    parameter int DIV0 = `SPS_DIV0,
    parameter int DIV1 = `SPS_DIV1,
    parameter int DIV2 = `SPS_DIV2,
    parameter int DIV3 = `SPS_DIV3
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic run_in,
    input wire logic [1:0] sel_in,
    output logic tick_out
);

    logic [15:0] cnt_reg;
    logic [15:0] half;

    // slow rates only; the slave side sees the clock through synchronisers
    if (DIV0 < `SPS_MIN_DIV || DIV1 < `SPS_MIN_DIV || DIV2 < `SPS_MIN_DIV ||
        DIV3 < `SPS_MIN_DIV || DIV0 % 2 != 0 || DIV1 % 2 != 0 ||
        DIV2 % 2 != 0 || DIV3 % 2 != 0 || DIV3 > 65534) begin : g_bad_div
        $error("sps_rate_div: divisors must be even and at least 4");
    end

    function automatic logic [15:0] half_of(input logic [1:0] sel);
        case (sel)
            2'h0: half_of = 16'(DIV0 / 2);
            2'h1: half_of = 16'(DIV1 / 2);
            2'h2: half_of = 16'(DIV2 / 2);
            default: half_of = 16'(DIV3 / 2);
        endcase
    endfunction

    assign half = half_of(sel_in);
    assign tick_out = run_in && (cnt_reg == half - 16'h0001);

    // restart on every run so the first half period is whole
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_reg <= 16'h0000;
        end else if (!run_in || tick_out) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

endmodule // sps_rate_div

`default_nettype wire

// ===== sps_port.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sps_defines.svh"

module sps_port
    import sps_pkg::*;
#(
    parameter int DIV0 = `SPS_DIV0,
    parameter int DIV1 = `SPS_DIV1,
    parameter int DIV2 = `SPS_DIV2,
    parameter int DIV3 = `SPS_DIV3
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic cpu_irq_mask_in,
    output logic port_irq_out,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_out,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_out,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_out,
    input wire logic ss_n_in
);

    // ****************************************
    // declarations
    // ****************************************
    sps_ctrl_t ctrl_reg;
    sps_stat_t stat_reg;
    sps_state_t state_reg;
    logic [2:0] armed_reg;
    logic [7:0] shift_reg;
    logic [7:0] rx_buf_reg;
    logic [2:0] bit_cnt_reg;
    logic in_bit_reg;
    logic out_bit_reg;
    logic sck_reg;
    logic sck_prev_reg;
    logic [31:0] prdata_reg;
    logic [3:0] sync_vec;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_n_s;
    logic bus_acc;
    logic sel_data;
    logic sel_ctrl;
    logic sel_stat;
    logic data_wr;
    logic data_acc;
    logic ctrl_wr;
    logic stat_acc;
    logic is_master;
    logic is_slave;
    logic busy;
    logic flag_block;
    logic frozen;
    logic data_load;
    logic coll_set;
    logic fault;
    logic tick;
    logic m_lead;
    logic m_trail;
    logic s_edge;
    logic lead_edge;
    logic trail_edge;
    logic last_trail;
    logic data_in;
    logic [7:0] ctrl_wr_val;

    function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic b);
        shift_in = {cur[6:0], b};
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    // two stages cost latency; slave clock must stay at or below half rate
    sps_pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in({sck_in, mosi_in, miso_in, ss_n_in}),
        .sync_out(sync_vec)
    );

    assign sck_s = sync_vec[3];
    assign mosi_s = sync_vec[2];
    assign miso_s = sync_vec[1];
    assign ss_n_s = sync_vec[0];

    // ****************************************
    // bus decode
    // ****************************************
    assign bus_acc = psel_in && penable_in;
    assign sel_data = (paddr_in == `SPS_OFS_DATA);
    assign sel_ctrl = (paddr_in == `SPS_OFS_CTRL);
    assign sel_stat = (paddr_in == `SPS_OFS_STAT);
    assign data_wr = bus_acc && pwrite_in && sel_data;
    assign data_acc = bus_acc && sel_data;
    assign ctrl_wr = bus_acc && pwrite_in && sel_ctrl;
    assign stat_acc = bus_acc && sel_stat;

    assign pready_out = 1'b1;
    assign pslverr_out = bus_acc && !(sel_data || sel_ctrl || sel_stat);
    assign prdata_out = prdata_reg;

    // read data taken in the setup cycle, so access phase needs no wait
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prdata_reg <= 32'h00000000;
        end else if (psel_in && !penable_in) begin
            if (sel_data) begin
                prdata_reg <= {24'h000000, rx_buf_reg};
            end else if (sel_ctrl) begin
                prdata_reg <= {24'h000000, ctrl_reg};
            end else if (sel_stat) begin
                prdata_reg <= {24'h000000, stat_reg};
            end else begin
                prdata_reg <= 32'h00000000;
            end
        end
    end

    // ****************************************
    // role and write qualification
    // ****************************************
    assign is_master = ctrl_reg.port_enable && ctrl_reg.master_select;
    assign is_slave = ctrl_reg.port_enable && !ctrl_reg.master_select;
    assign busy = (state_reg == SPS_SHIFT);
    assign flag_block = stat_reg.transfer_complete_flag && !armed_reg[0];
    // a selected slave with phase 0 may see its first edge at any moment
    assign frozen = busy || (is_slave && !ss_n_s && !ctrl_reg.clock_phase);
    assign data_load = data_wr && !flag_block && !frozen;
    assign coll_set = data_wr && !flag_block && frozen;
    assign fault = ctrl_reg.master_select && !ss_n_s;

    // ****************************************
    // clock edges
    // ****************************************
    sps_rate_div #(
        .DIV0(DIV0),
        .DIV1(DIV1),
        .DIV2(DIV2),
        .DIV3(DIV3)
    ) u_div (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .run_in(is_master && busy),
        .sel_in({ctrl_reg.rate_sel_hi, ctrl_reg.rate_sel_lo}),
        .tick_out(tick)
    );

    assign m_lead = tick && (sck_reg == ctrl_reg.clock_polarity);
    assign m_trail = tick && (sck_reg != ctrl_reg.clock_polarity);
    assign s_edge = is_slave && !ss_n_s && (sck_s != sck_prev_reg);
    assign lead_edge = is_master ? m_lead :
        (s_edge && (sck_prev_reg == ctrl_reg.clock_polarity));
    assign trail_edge = is_master ? m_trail :
        (s_edge && (sck_prev_reg != ctrl_reg.clock_polarity));
    assign last_trail = busy && trail_edge && (bit_cnt_reg == `SPS_LAST_BIT);
    assign data_in = is_master ? miso_s : mosi_s;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    // master clock rests at the polarity level between bytes
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_reg <= 1'b0;
        end else if (!is_master || !busy) begin
            sck_reg <= ctrl_reg.clock_polarity;
        end else if (tick) begin
            sck_reg <= !sck_reg;
        end
    end

    // ****************************************
    // transfer sequencer
    // ****************************************
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= SPS_IDLE;
        end else if (fault || !ctrl_reg.port_enable) begin
            state_reg <= SPS_IDLE;
        end else begin
            case (state_reg)
                SPS_IDLE: begin
                    if ((data_load && is_master) || (is_slave && lead_edge)) begin
                        state_reg <= SPS_SHIFT;
                    end
                end
                SPS_SHIFT: begin
                    if (last_trail || (is_slave && ss_n_s)) begin
                        state_reg <= SPS_IDLE;
                    end
                end
                default: begin
                    state_reg <= SPS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bit_cnt_reg <= 3'h0;
        end else if (!busy) begin
            bit_cnt_reg <= 3'h0;
        end else if (trail_edge) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // ****************************************
    // shift path
    // ****************************************
    // phase 0: capture on leading edge, shift on trailing edge
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            in_bit_reg <= 1'b0;
        end else if (lead_edge && !ctrl_reg.clock_phase) begin
            in_bit_reg <= data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shift_reg <= 8'h00;
        end else if (data_load) begin
            shift_reg <= pwdata_in[7:0];
        end else if (trail_edge) begin
            if (ctrl_reg.clock_phase) begin
                shift_reg <= shift_in(shift_reg, data_in);
            end else begin
                shift_reg <= shift_in(shift_reg, in_bit_reg);
            end
        end
    end

    // phase 1 presents each bit at the leading edge instead
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            out_bit_reg <= 1'b0;
        end else if (data_load) begin
            out_bit_reg <= pwdata_in[7];
        end else if (lead_edge && ctrl_reg.clock_phase) begin
            out_bit_reg <= shift_reg[7];
        end else if (trail_edge && !ctrl_reg.clock_phase) begin
            out_bit_reg <= shift_reg[6];
        end
    end

    // overrun keeps only the newest byte
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_buf_reg <= `SPS_BUF_RST;
        end else if (last_trail) begin
            if (ctrl_reg.clock_phase) begin
                rx_buf_reg <= shift_in(shift_reg, data_in);
            end else begin
                rx_buf_reg <= shift_in(shift_reg, in_bit_reg);
            end
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    // a status access only arms a clear for flags already set
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            armed_reg <= 3'h0;
        end else if (stat_acc) begin
            armed_reg[0] <= stat_reg.transfer_complete_flag;
            armed_reg[1] <= stat_reg.write_collision_flag;
            armed_reg[2] <= stat_reg.mode_fault_flag;
        end else begin
            if (data_acc) begin
                armed_reg[0] <= 1'b0;
                armed_reg[1] <= 1'b0;
            end
            if (ctrl_wr) begin
                armed_reg[2] <= 1'b0;
            end
        end
    end

    // set beats clear in the same cycle
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stat_reg <= `SPS_STAT_RST;
        end else begin
            if (last_trail) begin
                stat_reg.transfer_complete_flag <= 1'b1;
            end else if (armed_reg[0] && data_acc) begin
                stat_reg.transfer_complete_flag <= 1'b0;
            end
            if (coll_set) begin
                stat_reg.write_collision_flag <= 1'b1;
            end else if (armed_reg[1] && data_acc) begin
                stat_reg.write_collision_flag <= 1'b0;
            end
            if (fault) begin
                stat_reg.mode_fault_flag <= 1'b1;
            end else if (armed_reg[2] && ctrl_wr) begin
                stat_reg.mode_fault_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // control register
    // ****************************************
    // enable and master stay off under a fault unless the clear is armed
    always_comb begin
        ctrl_wr_val = pwdata_in[7:0] & `SPS_CTRL_WMASK;
        if (stat_reg.mode_fault_flag && !armed_reg[2]) begin
            ctrl_wr_val[6] = 1'b0;
            ctrl_wr_val[4] = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_reg <= `SPS_CTRL_RST;
        end else if (fault) begin
            ctrl_reg.port_enable <= 1'b0;
            ctrl_reg.master_select <= 1'b0;
        end else if (ctrl_wr) begin
            ctrl_reg <= ctrl_wr_val;
        end
    end

    // ****************************************
    // pins and interrupt
    // ****************************************
    assign sck_out = sck_reg;
    assign sck_oe_out = is_master;
    assign mosi_out = out_bit_reg;
    assign mosi_oe_out = is_master;
    assign miso_out = out_bit_reg;
    assign miso_oe_out = is_slave && !ss_n_s;
    // collision is status only and never requests service
    assign port_irq_out = ctrl_reg.port_irq_enable && !cpu_irq_mask_in &&
        (stat_reg.transfer_complete_flag || stat_reg.mode_fault_flag);

endmodule // sps_port

`default_nettype wire

// ===== sps_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "sps_defines.svh"

module sps_port_checker #(
    parameter int DIV0 = 4
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pslverr_out,
    input wire logic cpu_irq_mask_in,
    input wire logic port_irq_out,
    input wire logic sck_out,
    input wire logic sck_oe_out,
    input wire logic mosi_oe_out,
    input wire logic miso_oe_out,
    input wire logic ss_n_in
);
    // ****************************************
    // helper logic
    // ****************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    logic acc;
    logic mapped;
    logic sck_q;
    logic [7:0] hold_cnt;
    assign acc = psel_in && penable_in;
    assign mapped = paddr_in == `SPS_OFS_DATA || paddr_in == `SPS_OFS_CTRL ||
        paddr_in == `SPS_OFS_STAT;
    // cycles since the serial clock last moved
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sck_q <= 1'b0;
            hold_cnt <= 8'h00;
        end else begin
            sck_q <= sck_out;
            if (sck_out != sck_q) begin
                hold_cnt <= 8'h00;
            end else if (hold_cnt != 8'hFF) begin
                hold_cnt <= hold_cnt + 8'h01;
            end
        end
    end

    // ****************************************
    // properties
    // ****************************************
    property p_err;
        acc |-> pslverr_out == !mapped;
    endproperty
    a_err: assert property (p_err) else $error("slave error wrong");
    property p_rdhi;
        prdata_out[31:8] == 24'h000000;
    endproperty
    a_rdhi: assert property (p_rdhi) else $error("read data upper bits set");
    property p_hold;
        acc |=> $stable(prdata_out);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved after access");
    property p_irq;
        port_irq_out |-> !cpu_irq_mask_in;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt while masked");
    property p_oe;
        sck_oe_out == mosi_oe_out && !(sck_oe_out && miso_oe_out);
    endproperty
    a_oe: assert property (p_oe) else $error("pin directions inconsistent");
    property p_fault;
        !ss_n_in [*5] |-> !sck_oe_out;
    endproperty
    a_fault: assert property (p_fault) else $error("master kept with select low");
    property p_slv;
        ss_n_in [*4] |-> !miso_oe_out;
    endproperty
    a_slv: assert property (p_slv) else $error("slave output while deselected");
    property p_rate;
        sck_out != sck_q && sck_oe_out |-> hold_cnt >= 8'(DIV0 / 2 - 1);
    endproperty
    a_rate: assert property (p_rate) else $error("serial clock too fast");
    property p_idle;
        acc && pwrite_in && paddr_in == `SPS_OFS_CTRL && pwdata_in[6] && pwdata_in[4] &&
            ss_n_in |-> ##2 sck_out == $past(pwdata_in[3], 2);
    endproperty
    a_idle: assert property (p_idle) else $error("idle clock level wrong");
    c_data: cover property (acc && pwrite_in && paddr_in == `SPS_OFS_DATA);
    c_irq: cover property ($rose(port_irq_out));
    c_rel: cover property ($fell(sck_oe_out));
endmodule // sps_port_checker

bind sps_port sps_port_checker #(.DIV0(DIV0)) sps_port_checker_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .cpu_irq_mask_in(cpu_irq_mask_in), .port_irq_out(port_irq_out), .sck_out(sck_out),
    .sck_oe_out(sck_oe_out), .mosi_oe_out(mosi_oe_out), .miso_oe_out(miso_oe_out),
    .ss_n_in(ss_n_in));
`default_nettype wire

// ===== sps_slave_model.sv
`timescale 1ns/1ns
`default_nettype none

module sps_slave_model (
    input wire logic sck_in,
    input wire logic sel_in,
    input wire logic mosi_in,
    input wire logic pol_in,
    input wire logic pha_in,
    input wire logic [7:0] tx_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    logic [7:0] shift_reg;
    initial begin
        miso_out = 1'b0;
        rx_out = 8'h00;
        shift_reg = 8'h00;
    end
    // no pull on the line: a released output shows the inverse of its last bit
    always @(sel_in) begin
        shift_reg = tx_in;
        if (sel_in && !pha_in) begin
            miso_out = shift_reg[7];
            shift_reg = shift_reg << 1;
        end else if (!sel_in) begin
            miso_out = !miso_out;
        end
    end
    // leading edge leaves the idle level
    always @(sck_in) begin
        if (sel_in && ((sck_in != pol_in) == pha_in)) begin
            miso_out = shift_reg[7];
            shift_reg = shift_reg << 1;
        end else if (sel_in) begin
            rx_out = {rx_out[6:0], mosi_in};
        end
    end
endmodule // sps_slave_model
`default_nettype wire

// ===== spi_master_slave_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "sps_defines.svh"

module spi_master_slave_port_bench;
    localparam int DIV[4] = '{8, 12, 16, 20};
    localparam logic [7:0] TXB[4] = '{8'hA5, 8'h01, 8'h80, 8'h3C};
    localparam logic [7:0] RXB[4] = '{8'h5E, 8'hFF, 8'h7F, 8'hC3};
    logic mclk_in, reset_n_in, psel, penable, pwrite, mask, ss_n, sel, pol, pha, rerr;
    logic ext_sck, ext_mosi;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata;
    logic pready, pslverr, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, s_miso;
    logic [7:0] stx, s_rx;
    int errors = 0;
    int samples_checked = 0;
    wire logic sck_w = sck_oe ? sck_o : ext_sck;
    wire logic mosi_w = mosi_oe ? mosi_o : ext_mosi;
    wire logic miso_w = miso_oe ? miso_o : s_miso;

    sps_port #(.DIV0(8), .DIV1(12), .DIV2(16), .DIV3(20)) sps_port_i (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .cpu_irq_mask_in(mask),
        .port_irq_out(irq), .sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe), .miso_in(miso_w),
        .miso_out(miso_o), .miso_oe_out(miso_oe), .ss_n_in(ss_n));
    sps_slave_model sps_slave_model_i (.sck_in(sck_w), .sel_in(sel), .mosi_in(mosi_w),
        .pol_in(pol), .pha_in(pha), .tx_in(stx), .miso_out(s_miso), .rx_out(s_rx));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    // entered just after a rising edge; leaves one edge after release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        @(posedge mclk_in);
        while (pready !== 1'b1) @(posedge mclk_in);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_in);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        apb(1'b0, `SPS_OFS_CTRL, 32'h0);
        chk(rd, 32'h0, "control reset value");
        apb(1'b0, `SPS_OFS_STAT, 32'h0);
        chk(rd, 32'h0, "status reset value");
        apb(1'b0, `SPS_OFS_DATA, 32'h0);
        chk(rd, 32'h0, "data reset value");
        apb(1'b0, 12'h00C, 32'h0);
        chk({rd[30:0], rerr}, 32'h1, "unmapped access");
    endtask
    task automatic t_xfer(input int m, input int r, input logic [7:0] tx, input logic [7:0] srx);
        int n;
        pol <= m[1];
        pha <= m[0];
        stx <= srx;
        apb(1'b1, `SPS_OFS_CTRL, 32'hD0 | (m << 2) | r);
        // select only after a polarity change has settled
        @(posedge mclk_in);
        sel <= 1'b1;
        apb(1'b1, `SPS_OFS_DATA, {24'h0, tx});
        chk(mosi_o, tx[7], "first bit out");
        n = 0;
        while (sck_o === pol && n < 100) begin
            @(negedge mclk_in);
            n++;
        end
        n = 0;
        while (sck_o !== pol && n < 100) begin
            @(negedge mclk_in);
            n++;
        end
        chk(n, DIV[r] / 2, "half period");
        @(posedge mclk_in);
        apb(1'b1, `SPS_OFS_DATA, {24'h0, ~tx});
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(negedge mclk_in);
            n++;
        end
        chk(irq, 1'b1, "completion interrupt");
        chk(s_rx, tx, "byte at slave");
        @(posedge mclk_in);
        mask <= 1'b1;
        @(negedge mclk_in);
        chk(irq, 1'b0, "masked interrupt");
        @(posedge mclk_in);
        mask <= 1'b0;
        apb(1'b1, `SPS_OFS_DATA, 32'h5A);
        repeat (DIV[r]) @(negedge mclk_in);
        chk(sck_o, pol, "no restart, idle level");
        @(posedge mclk_in);
        apb(1'b0, `SPS_OFS_STAT, 32'h0);
        chk(rd, 32'hC0, "complete and collision");
        apb(1'b0, `SPS_OFS_DATA, 32'h0);
        chk(rd, {24'h0, srx}, "received byte");
        apb(1'b0, `SPS_OFS_STAT, 32'h0);
        chk(rd, 32'h0, "flags cleared");
        sel <= 1'b0;
    endtask
    task automatic t_fault;
        apb(1'b1, `SPS_OFS_CTRL, 32'hD0);
        ss_n <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk(sck_oe, 1'b0, "pins released");
        chk(irq, 1'b1, "fault interrupt");
        apb(1'b0, `SPS_OFS_CTRL, 32'h0);
        chk(rd, 32'h80, "enable and master cleared");
        ss_n <= 1'b1;
        apb(1'b0, `SPS_OFS_STAT, 32'h0);
        chk(rd, 32'h10, "fault flag");
        apb(1'b1, `SPS_OFS_CTRL, 32'h0);
        apb(1'b0, `SPS_OFS_STAT, 32'h0);
        chk(rd, 32'h0, "fault cleared");
    endtask
    task automatic t_slave;
        logic [7:0] got, mo;
        got = 8'h00;
        mo = 8'h4B;
        apb(1'b1, `SPS_OFS_CTRL, 32'hC0);
        apb(1'b1, `SPS_OFS_DATA, 32'h96);
        ss_n <= 1'b0;
        for (int b = 7; b >= 0; b--) begin
            ext_mosi <= mo[b];
            repeat (4) @(posedge mclk_in);
            got = {got[6:0], miso_w};
            ext_sck <= 1'b1;
            repeat (4) @(posedge mclk_in);
            ext_sck <= 1'b0;
            repeat (4) @(posedge mclk_in);
        end
        chk(got, 8'h96, "slave byte out");
        chk(irq, 1'b1, "slave completion interrupt");
        apb(1'b0, `SPS_OFS_STAT, 32'h0);
        chk(rd, 32'h80, "slave complete");
        apb(1'b0, `SPS_OFS_DATA, 32'h0);
        chk(rd, 32'h4B, "slave byte in");
        ss_n <= 1'b1;
    endtask

    // ****************************************
    // clock, reset, sequence, watchdog
    // ****************************************
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    initial begin
        #(20 * 6000);
        errors++;
        wrap_up();
    end
    initial begin
        {psel, penable, pwrite, mask, sel, pol, pha, ext_sck, ext_mosi} = 9'h000;
        ss_n = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        stx = 8'h00;
        reset_n_in = 1'b0;
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        for (int i = 0; i < 4; i++) begin
            t_xfer(i, 3 - i, TXB[i], RXB[i]);
        end
        t_fault();
        t_slave();
        wrap_up();
    end
endmodule // spi_master_slave_port_bench
`default_nettype wire
